//--- verilog/fewp_ctrl.sv
// command decode, write enable latch, protection and erase timer
`timescale 1ns/1ns
`include "fewp_defines.svh"
module fewp_ctrl #(
	parameter int unsigned FULL_ERASE_CYCLES = `FEWP_FULL_ERASE_CYCLES
) (
	input wire logic I_MCLK,
	input wire logic I_RSTN,
	input wire logic I_SCK,
	input wire logic I_CSN,
	input wire logic I_SI,
	input wire logic I_WPN,
	input wire logic I_NV_PROTECT,
	input wire logic I_ERASE_FAIL,
	output logic O_BUSY,
	output logic O_WRITE_ENABLE_LATCH,
	output logic O_ARRAY_PROTECT,
	output logic O_PROTECT_LOCK,
	output logic O_ERASE_PROGRAM_ERROR,
	output logic O_HW_LOCKED,
	output logic O_ERASE_START,
	output logic O_NV_STORE
);

	// link side, clocked by the serial clock
	logic frame_rstn;
	logic in_frame_reg;
	logic frame_tgl_reg;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic [2:0] bit_cnt_reg;
	logic [2:0] bit_cnt_next;
	logic [1:0] byte_cnt_reg;
	logic [1:0] byte_cnt_base;
	logic [1:0] byte_cnt_next;
	logic [7:0] opcode_reg;
	logic [7:0] data_reg;
	logic byte_done;

	assign frame_rstn = I_RSTN & ~I_CSN;
	assign shift_next = {shift_reg[6:0], I_SI};
	assign bit_cnt_next = in_frame_reg ? bit_cnt_reg + 3'h1 : 3'h1;
	assign byte_cnt_base = in_frame_reg ? byte_cnt_reg : 2'h0;
	assign byte_done = (bit_cnt_next == 3'h0);
	assign byte_cnt_next = (byte_done && byte_cnt_base != 2'h3) ? byte_cnt_base + 2'h1 : byte_cnt_base;

	// in-frame flag drops as soon as chip select rises
	always_ff @(posedge I_SCK or negedge frame_rstn) begin
		if (!frame_rstn) begin
			in_frame_reg <= 1'b0;
		end else begin
			in_frame_reg <= 1'b1;
		end
	end

	// counts restart on the first edge of a frame, so they stay put after it
	always_ff @(posedge I_SCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			frame_tgl_reg <= 1'b0;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 2'h0;
		end else begin
			frame_tgl_reg <= frame_tgl_reg ^ ~in_frame_reg;
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			byte_cnt_reg <= byte_cnt_next;
		end
	end

	// first byte is the opcode, second the status byte; later bytes ignored
	always_ff @(posedge I_SCK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			opcode_reg <= 8'h00;
			data_reg <= 8'h00;
		end else begin
			if (byte_done && byte_cnt_base == 2'h0) begin
				opcode_reg <= shift_next;
			end
			if (byte_done && byte_cnt_base == 2'h1) begin
				data_reg <= shift_next;
			end
		end
	end

	// system side synchronisers
	logic csn_s1_reg;
	logic csn_s2_reg;
	logic csn_d_reg;
	logic wpn_s1_reg;
	logic wpn_s2_reg;
	logic tgl_s1_reg;
	logic tgl_s2_reg;
	logic tgl_seen_reg;

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			csn_s1_reg <= 1'b1;
			csn_s2_reg <= 1'b1;
			csn_d_reg <= 1'b1;
			wpn_s1_reg <= 1'b1;
			wpn_s2_reg <= 1'b1;
			tgl_s1_reg <= 1'b0;
			tgl_s2_reg <= 1'b0;
		end else begin
			csn_s1_reg <= I_CSN;
			csn_s2_reg <= csn_s1_reg;
			csn_d_reg <= csn_s2_reg;
			wpn_s1_reg <= I_WPN;
			wpn_s2_reg <= wpn_s1_reg;
			tgl_s1_reg <= frame_tgl_reg;
			tgl_s2_reg <= tgl_s1_reg;
		end
	end

	// decode at chip select release; link values are frozen by then
	logic frame_end;
	logic fresh;
	logic opcode_done;
	logic aligned;
	logic is_erase;
	logic is_wren;
	logic is_wrdi;
	logic is_wrsr;
	logic idle;
	logic hw_locked;
	logic erase_go;
	logic erase_abort;
	logic wrsr_go;
	logic wren_go;
	logic wrdi_go;
	logic erase_done;

	fewp_pkg::fewp_state_t state_reg;
	fewp_pkg::fewp_state_t state_next;
	logic [31:0] erase_cnt_reg;
	logic [31:0] erase_cnt_next;
	logic wel_reg;
	logic wel_next;
	logic protect_reg;
	logic protect_next;
	logic lock_reg;
	logic lock_next;
	logic err_reg;
	logic err_next;
	logic nv_loaded_reg;

	assign frame_end = csn_s2_reg & ~csn_d_reg;
	assign fresh = (tgl_s2_reg != tgl_seen_reg);
	assign opcode_done = fresh && (byte_cnt_reg != 2'h0);
	assign aligned = opcode_done && (bit_cnt_reg == 3'h0);
	assign is_erase = (opcode_reg == `FEWP_OP_FULL_ERASE_A) || (opcode_reg == `FEWP_OP_FULL_ERASE_B)
		|| (opcode_reg == `FEWP_OP_FULL_ERASE_C);
	assign is_wren = (opcode_reg == `FEWP_OP_WRITE_ENABLE);
	assign is_wrdi = (opcode_reg == `FEWP_OP_WRITE_DISABLE);
	assign is_wrsr = (opcode_reg == `FEWP_OP_STATUS_WRITE);
	assign idle = (state_reg == fewp_pkg::FEWP_IDLE);
	assign hw_locked = ~wpn_s2_reg & lock_reg;
	// protect bit one covers the whole array, zero covers none
	assign erase_go = frame_end & aligned & is_erase & wel_reg & ~protect_reg & idle;
	assign erase_abort = frame_end & opcode_done & is_erase & wel_reg & idle
		& ((bit_cnt_reg != 3'h0) | protect_reg);
	assign wrsr_go = frame_end & aligned & is_wrsr & (byte_cnt_reg >= 2'h2) & wel_reg
		& ~hw_locked & idle;
	assign wren_go = frame_end & aligned & is_wren & idle;
	assign wrdi_go = frame_end & aligned & is_wrdi & idle;
	assign erase_done = ~idle && (erase_cnt_reg == 32'h0000_0001);

	assign state_next = erase_go ? fewp_pkg::FEWP_ERASE : (erase_done ? fewp_pkg::FEWP_IDLE : state_reg);
	assign erase_cnt_next = erase_go ? FULL_ERASE_CYCLES : (idle ? 32'h0 : erase_cnt_reg - 32'h1);

	// latch cleared at erase start, well before the erase ends
	assign wel_next = (erase_go | erase_abort | wrsr_go | wrdi_go) ? 1'b0
		: (wren_go ? 1'b1 : wel_reg);

	// lock may always go up; it comes down only through a write with pin high
	assign lock_next = wrsr_go ? (data_reg[`FEWP_SR_LOCK_POS] | (lock_reg & ~wpn_s2_reg)) : lock_reg;
	assign protect_next = !nv_loaded_reg ? I_NV_PROTECT
		: (wrsr_go ? data_reg[`FEWP_SR_PROTECT_POS] : protect_reg);
	assign err_next = erase_go ? 1'b0 : ((~idle & I_ERASE_FAIL) ? 1'b1 : err_reg);

	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			tgl_seen_reg <= 1'b0;
			state_reg <= fewp_pkg::FEWP_IDLE;
			erase_cnt_reg <= 32'h0;
		end else begin
			if (frame_end) begin
				tgl_seen_reg <= tgl_s2_reg;
			end
			state_reg <= state_next;
			erase_cnt_reg <= erase_cnt_next;
		end
	end

	// protect bit reloads from nonvolatile storage after reset
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			wel_reg <= 1'b0;
			protect_reg <= `FEWP_PROTECT_DEFAULT;
			lock_reg <= 1'b0;
			err_reg <= 1'b0;
			nv_loaded_reg <= 1'b0;
		end else begin
			wel_reg <= wel_next;
			protect_reg <= protect_next;
			lock_reg <= lock_next;
			err_reg <= err_next;
			nv_loaded_reg <= 1'b1;
		end
	end

	// outputs
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_BUSY <= 1'b0;
			O_WRITE_ENABLE_LATCH <= 1'b0;
			O_ARRAY_PROTECT <= `FEWP_PROTECT_DEFAULT;
			O_PROTECT_LOCK <= 1'b0;
			O_ERASE_PROGRAM_ERROR <= 1'b0;
			O_HW_LOCKED <= 1'b0;
			O_ERASE_START <= 1'b0;
			O_NV_STORE <= 1'b0;
		end else begin
			O_BUSY <= (state_next == fewp_pkg::FEWP_ERASE);
			O_WRITE_ENABLE_LATCH <= wel_next;
			O_ARRAY_PROTECT <= protect_next;
			O_PROTECT_LOCK <= lock_next;
			O_ERASE_PROGRAM_ERROR <= err_next;
			O_HW_LOCKED <= ~wpn_s2_reg & lock_next;
			O_ERASE_START <= erase_go;
			O_NV_STORE <= wrsr_go;
		end
	end

endmodule // fewp_ctrl

//--- verilog/fewp_defines.svh
// constants for the erase, write-enable and protection command logic
// Operation
// - erase needs write enable latch already set
// - three opcodes all mean full erase
// - erase ignores extra bytes, starts at deselect
// - no erase on short or unaligned frame
// - protected array: erase skipped, back to idle
// - aborted erase clears write enable latch
// - busy during erase, latch cleared before end
// - failed byte erase sets error flag
// - write commands refused without write enable latch
// - write enable sets latch on aligned frame
// - write disable clears latch on aligned frame
// - protect bit one protects whole array
// - protect bit blocks program and erase
// - protect bit nonvolatile, default zero
// - write protect pin never guards array directly
// - hardware lock: pin low and lock set
// - hardware lock freezes bits, ignores status write
// - lock settable anytime; pin low keeps it
// - pin high: lock does not freeze protect
// - pin high: status write may clear lock
`ifndef FEWP_DEFINES_SVH
`define FEWP_DEFINES_SVH

`define FEWP_OP_WRITE_ENABLE 8'h06
`define FEWP_OP_WRITE_DISABLE 8'h04
`define FEWP_OP_FULL_ERASE_A 8'h60
`define FEWP_OP_FULL_ERASE_B 8'h62
`define FEWP_OP_FULL_ERASE_C 8'hc7
`define FEWP_OP_STATUS_WRITE 8'h01

`define FEWP_SR_PROTECT_POS 2
`define FEWP_SR_LOCK_POS 7

`define FEWP_PROTECT_DEFAULT 1'b0
`define FEWP_MCLK_MHZ 50
`define FEWP_FULL_ERASE_TIME_US 1000
`define FEWP_FULL_ERASE_CYCLES (`FEWP_FULL_ERASE_TIME_US * `FEWP_MCLK_MHZ)

`endif

//--- verilog/fewp_pkg.sv
// types for the erase, write-enable and protection command logic
package fewp_pkg;
	typedef enum logic [0:0] {
		FEWP_IDLE = 1'b0,
		FEWP_ERASE = 1'b1
	} fewp_state_t;
endpackage

//--- sim/fewp_ctrl_asserts.sv
// checker for the erase and protection control
`timescale 1ns/1ns
module fewp_ctrl_asserts #(
	parameter int unsigned FULL_ERASE_CYCLES = 20
) (
	input wire logic I_MCLK,
	input wire logic I_RSTN,
	input wire logic O_BUSY,
	input wire logic O_WRITE_ENABLE_LATCH,
	input wire logic O_ARRAY_PROTECT,
	input wire logic O_PROTECT_LOCK,
	input wire logic O_ERASE_PROGRAM_ERROR,
	input wire logic O_HW_LOCKED,
	input wire logic O_ERASE_START,
	input wire logic O_NV_STORE
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RSTN);
	int busy_cnt;
	always_ff @(posedge I_MCLK or negedge I_RSTN) begin
		if (!I_RSTN)
			busy_cnt <= 0;
		else
			busy_cnt <= O_BUSY ? busy_cnt + 1 : 0;
	end
	property p_wel; O_ERASE_START |-> $past(O_WRITE_ENABLE_LATCH); endproperty
	a_wel: assert property (p_wel) else $error("erase without latch");
	property p_start; O_ERASE_START |-> O_BUSY && !O_WRITE_ENABLE_LATCH; endproperty
	a_start: assert property (p_start) else $error("bad erase start");
	property p_prot; O_ERASE_START |-> !O_ARRAY_PROTECT; endproperty
	a_prot: assert property (p_prot) else $error("erase while protected");
	property p_src; $rose(O_BUSY) |-> O_ERASE_START; endproperty
	a_src: assert property (p_src) else $error("busy without start");
	property p_len; $fell(O_BUSY) |-> busy_cnt == FULL_ERASE_CYCLES; endproperty
	a_len: assert property (p_len) else $error("busy length wrong");
	property p_lock; O_HW_LOCKED |-> O_PROTECT_LOCK; endproperty
	a_lock: assert property (p_lock) else $error("lock without lock bit");
	property p_frz; O_HW_LOCKED |=> $stable(O_ARRAY_PROTECT) && $stable(O_PROTECT_LOCK); endproperty
	a_frz: assert property (p_frz) else $error("locked bits changed");
	property p_nv; O_NV_STORE |-> $past(O_WRITE_ENABLE_LATCH) && !O_WRITE_ENABLE_LATCH; endproperty
	a_nv: assert property (p_nv) else $error("store without latch");
	property p_epe; $rose(O_ERASE_PROGRAM_ERROR) |-> $past(O_BUSY); endproperty
	a_epe: assert property (p_epe) else $error("error flag while idle");
	c_erase: cover property (O_ERASE_START);
	c_store: cover property (O_NV_STORE);
	c_locked: cover property (O_HW_LOCKED);
endmodule // fewp_ctrl_asserts
bind fewp_ctrl fewp_ctrl_asserts #(.FULL_ERASE_CYCLES(FULL_ERASE_CYCLES)) u_fewp_ctrl_asserts (.I_MCLK, .I_RSTN,
	.O_BUSY, .O_WRITE_ENABLE_LATCH, .O_ARRAY_PROTECT, .O_PROTECT_LOCK, .O_ERASE_PROGRAM_ERROR, .O_HW_LOCKED,
	.O_ERASE_START, .O_NV_STORE);

//--- sim/fewp_host.sv
// host serial master model
`timescale 1ns/1ns
module fewp_host (
	output logic o_sck,
	output logic o_csn,
	output logic o_si
);
	initial begin
		o_sck = 1'b0;
		o_csn = 1'b1;
		o_si = 1'b0;
	end
	// msb first, clock still between frames
	task automatic frame(input logic [15:0] data, input int nbits);
		o_csn = 1'b0;
		#7;
		for (int i = 0; i < nbits; i++) begin
			o_si = data[15 - i];
			#15 o_sck = 1'b1;
			#15 o_sck = 1'b0;
		end
		#8 o_csn = 1'b1;
		o_si = ~o_si;
		#100;
	endtask
endmodule // fewp_host

//--- sim/fewp_ctrl_tb.sv
// bench for the erase and protection control
`timescale 1ns/1ns
module fewp_ctrl_tb;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic wpn = 1'b1;
	logic fail = 1'b0;
	logic nv = 1'b0;
	logic sck, csn, si, busy, write_enable_latch, prot, lock, erase_program_error, hwl, start, store;
	int n_start = 0;
	int n_store = 0;
	int num_errors = 0;
	int total_checks = 0;
	logic [7:0] ops [3] = '{8'h60, 8'h62, 8'hc7};
	always #10 mclk = ~mclk;
	fewp_host u_fewp_host (.o_sck(sck), .o_csn(csn), .o_si(si));
	fewp_ctrl #(.FULL_ERASE_CYCLES(20)) u_fewp_ctrl (.I_MCLK(mclk), .I_RSTN(rstn), .I_SCK(sck), .I_CSN(csn),
		.I_SI(si), .I_WPN(wpn), .I_NV_PROTECT(nv), .I_ERASE_FAIL(fail), .O_BUSY(busy),
		.O_WRITE_ENABLE_LATCH(write_enable_latch), .O_ARRAY_PROTECT(prot), .O_PROTECT_LOCK(lock),
		.O_ERASE_PROGRAM_ERROR(erase_program_error), .O_HW_LOCKED(hwl), .O_ERASE_START(start), .O_NV_STORE(store));
	// count one-cycle pulses
	always @(posedge mclk) begin
		if (start === 1'b1)
			n_start++;
		if (store === 1'b1)
			n_store++;
	end
	task automatic chk(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: got %b want %b", $time, got, exp);
		end
	endtask
	// frames start just after a system edge so checks right after a frame never land on one
	task automatic xfer(input logic [15:0] d, input int nbits);
		@(posedge mclk);
		#1;
		u_fewp_host.frame(d, nbits);
	endtask
	task automatic cmd(input logic [7:0] op, input int nbits);
		xfer({op, 8'h00}, nbits);
	endtask
	task automatic wr(input logic [7:0] val);
		cmd(8'h06, 8);
		xfer({8'h01, val}, 16);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		chk(busy, 1'b0);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		#1 rstn = 1'b1;
		repeat (5) @(posedge mclk);
		chk(prot, 1'b0);
		cmd(8'h06, 7);
		chk(write_enable_latch, 1'b0);
		cmd(8'h06, 16);
		chk(write_enable_latch, 1'b1);
		cmd(8'h04, 5);
		chk(write_enable_latch, 1'b1);
		cmd(8'h04, 16);
		chk(write_enable_latch, 1'b0);
		cmd(8'h60, 8);
		chk(busy, 1'b0);
		foreach (ops[i]) begin
			@(posedge mclk);
			#1 fail = (ops[i] == 8'hc7);
			cmd(8'h06, 8);
			cmd(ops[i], 16);
			chk(busy, 1'b1);
			chk(write_enable_latch, 1'b0);
			wait_idle();
			chk(erase_program_error, ops[i] == 8'hc7);
		end
		@(posedge mclk);
		#1 fail = 1'b0;
		cmd(8'h06, 8);
		cmd(8'h60, 12);
		chk(busy, 1'b0);
		chk(write_enable_latch, 1'b0);
		xfer(16'h0104, 16);
		chk(prot, 1'b0);
		wr(8'h04);
		chk(prot, 1'b1);
		cmd(8'h06, 8);
		cmd(8'hc7, 8);
		chk(busy, 1'b0);
		chk(write_enable_latch, 1'b0);
		wr(8'h84);
		chk(lock, 1'b1);
		chk(hwl, 1'b0);
		wr(8'h00);
		chk(lock, 1'b0);
		chk(prot, 1'b0);
		wr(8'h80);
		@(posedge mclk);
		#1 wpn = 1'b0;
		repeat (4) @(posedge mclk);
		chk(hwl, 1'b1);
		wr(8'h04);
		chk(prot, 1'b0);
		chk(lock, 1'b1);
		cmd(8'h06, 8);
		cmd(8'h62, 8);
		chk(busy, 1'b1);
		wait_idle();
		@(posedge mclk);
		#1 nv = 1'b1;
		rstn = 1'b0;
		repeat (3) @(posedge mclk);
		#1 rstn = 1'b1;
		repeat (5) @(posedge mclk);
		#1;
		chk(prot, 1'b1);
		chk(lock, 1'b0);
		chk(hwl, 1'b0);
		cmd(8'h06, 8);
		cmd(8'h60, 8);
		chk(busy, 1'b0);
		chk(n_start == 4, 1'b1);
		chk(n_store == 4, 1'b1);
		complete_run();
	end
	initial begin
		#100000;
		num_errors++;
		complete_run();
	end
endmodule // fewp_ctrl_tb
